// File: pldrc_pkg.sv
// package: field layout and constants for the first loop control fields
package pldrc_pkg;
  localparam int unsigned CFG_W = 32;
  localparam int unsigned BIT_OUT_RST = 13;
  localparam int unsigned BIT_FORCE_RST = 12;
  localparam int unsigned BIT_PHASE_BACK = 11;
  localparam int unsigned BIT_RATIONAL = 10;
  localparam int unsigned DEN_HI_MSB = 9;
  localparam int unsigned DEN_HI_W = 10;
  localparam int unsigned DEN_LO_W = 6;
  localparam int unsigned DEN_W = 16;
  localparam int unsigned FRAC_W = 28;
  localparam int unsigned NUM_LSB = 9;
  localparam int unsigned NUM_MSB = 24;
  localparam int unsigned SYNC_CYCLES = 8;
  localparam logic [3:0] SYNC_CNT_W1 = 4'h7;
  localparam logic [CFG_W-1:0] CFG_RESET = 32'h0000_0000;
  localparam logic [1:0] INTERP_EIGHT = 2'h0;
  localparam logic [1:0] INTERP_FOUR = 2'h1;
  localparam logic [1:0] INTERP_TWO = 2'h2;
  localparam logic [1:0] INTERP_NONE = 2'h3;

  typedef struct packed {
    logic rational;
    logic interp_bypass;
    logic [DEN_W-1:0] denominator;
    logic [DEN_W-1:0] numerator;
    logic [FRAC_W-1:0] fixed_frac;
    logic invalid;
  } pldrc_ratio_t;
endpackage : pldrc_pkg

// File: pldrc_ratio.sv
// feedback ratio selection between fixed-point and rational interpretation
`timescale 1ns/1ps
module pldrc_ratio (
  input wire logic mclk,
  input wire logic srst,
  input wire logic rational_en,
  input wire logic [1:0] interp_order,
  input wire logic [pldrc_pkg::DEN_HI_W-1:0] loop_a_denominator_hi,
  input wire logic [pldrc_pkg::FRAC_W-1:0] loop_a_frac_divisor,
  output pldrc_pkg::pldrc_ratio_t ratio
);
  pldrc_pkg::pldrc_ratio_t ratio_d;
  pldrc_pkg::pldrc_ratio_t ratio_q;
  logic [pldrc_pkg::DEN_W-1:0] den;

  always_comb begin
    // low denominator bits live in the unused low fraction bits
    den = {loop_a_denominator_hi, loop_a_frac_divisor[pldrc_pkg::DEN_LO_W-1:0]};
    ratio_d = '0;
    ratio_d.denominator = den;
    ratio_d.numerator = loop_a_frac_divisor[pldrc_pkg::NUM_MSB:pldrc_pkg::NUM_LSB];
    ratio_d.fixed_frac = loop_a_frac_divisor;
    ratio_d.rational = rational_en && (den != '0);
    ratio_d.interp_bypass = (interp_order == pldrc_pkg::INTERP_NONE);
    // flag only; software must avoid numerator above denominator
    ratio_d.invalid = ratio_d.rational && (ratio_d.numerator > den);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ratio_q <= '0;
    end else begin
      ratio_q <= ratio_d;
    end
  end

  assign ratio = ratio_q;
endmodule : pldrc_ratio

// File: pll_divider_rational_ctrl.sv
// lower control fields of the first loop configuration register
`timescale 1ns/1ps
// Summary of operation
// - output pair reset bit resets both drivers of the first output pair
// - force reset bit starts a sync pulse cycle to both loops' outputs
// - phase back bit retards oscillator output by one eighth cycle
// - phase shift acts on rising edge only; re-arm needs bit low
// - rational bit selects numerator from fraction bits 24..9 over denominator
// - denominator is 16 bits; upper ten held in register bits 9..0
// - zero denominator means fraction is plain 28-bit fixed point
// - rational ratio only when denominator nonzero and rational bit set
// - with no interpolation, divider is integer plus numerator over denominator
// - interpolation order 0 eight, 1 four, 2 two phases, 3 none
// - denominator low six bits share the lowest six fraction bits
module pll_divider_rational_ctrl (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cfg_wr,
  input wire logic [pldrc_pkg::CFG_W-1:0] cfg_wdata,
  input wire logic [1:0] interp_order,
  input wire logic [pldrc_pkg::FRAC_W-1:0] loop_a_frac_divisor,
  output logic [pldrc_pkg::CFG_W-1:0] cfg_rdata,
  output logic out_pair_a_driver_reset,
  output logic sync_pulse_loop_a,
  output logic sync_pulse_loop_b,
  output logic loop_a_phase_back,
  output logic force_reset_busy,
  output pldrc_pkg::pldrc_ratio_t ratio
);
  // one-hot codes; any other code falls back to idle
  typedef enum logic [1:0] {
    PLDRC_IDLE = 2'b01,
    PLDRC_SYNC = 2'b10
  } pldrc_state_t;

  // register image and its next value
  logic [pldrc_pkg::CFG_W-1:0] cfg_q;
  logic [pldrc_pkg::CFG_W-1:0] cfg_d;

  // phase step edge detector
  logic back_prev_q;
  logic back_prev_d;
  logic back_step_q;
  logic back_step_d;

  // force reset edge detector
  logic force_prev_q;
  logic force_prev_d;

  // sync cycle sequencer, counter and pulse
  pldrc_state_t st_q;
  pldrc_state_t st_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic sync_q;
  logic sync_d;

  // decoded control fields
  logic out_rst_bit;
  logic force_bit;
  logic back_bit;
  logic rational_bit;
  logic [pldrc_pkg::DEN_HI_W-1:0] den_hi_bits;
  logic force_start;
  logic sync_busy;
  logic sync_last;

  // rising edge of a register bit against its copy one cycle older
  function automatic logic rise_edge(
    input logic cur,
    input logic prev
  );
    rise_edge = cur && !prev;
  endfunction : rise_edge

  // one control bit of the register image
  function automatic logic cfg_bit(
    input logic [pldrc_pkg::CFG_W-1:0] cfg,
    input int unsigned pos
  );
    cfg_bit = cfg[pos];
  endfunction : cfg_bit

  // field taps from the register image
  assign out_rst_bit = cfg_bit(cfg_q, pldrc_pkg::BIT_OUT_RST);
  assign force_bit = cfg_bit(cfg_q, pldrc_pkg::BIT_FORCE_RST);
  assign back_bit = cfg_bit(cfg_q, pldrc_pkg::BIT_PHASE_BACK);
  assign rational_bit = cfg_bit(cfg_q, pldrc_pkg::BIT_RATIONAL);
  assign den_hi_bits = cfg_q[pldrc_pkg::DEN_HI_MSB:0];
  assign force_start = rise_edge(force_bit, force_prev_q);
  assign sync_busy = (st_q == PLDRC_SYNC);
  assign sync_last = (cnt_q == pldrc_pkg::SYNC_CNT_W1);

  // register image: a write replaces the whole word
  always_comb begin
    cfg_d = cfg_q;
    if (cfg_wr) begin
      cfg_d = cfg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_q <= pldrc_pkg::CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // one step per rising edge; holding the bit high does nothing more
  always_comb begin
    back_prev_d = back_bit;
    back_step_d = rise_edge(back_bit, back_prev_q);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      back_prev_q <= 1'b0;
      back_step_q <= 1'b0;
    end else begin
      back_prev_q <= back_prev_d;
      back_step_q <= back_step_d;
    end
  end

  // force reset is edge triggered, so a held bit starts one cycle only
  always_comb begin
    force_prev_d = force_bit;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      force_prev_q <= 1'b0;
    end else begin
      force_prev_q <= force_prev_d;
    end
  end

  // force edges seen while busy are dropped, not queued
  always_comb begin
    st_d = st_q;
    case (st_q)
      PLDRC_IDLE: begin
        if (force_start) begin
          st_d = PLDRC_SYNC;
        end
      end
      PLDRC_SYNC: begin
        if (sync_last) begin
          st_d = PLDRC_IDLE;
        end
      end
      // unreachable codes recover to idle
      default: begin
        st_d = PLDRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= PLDRC_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // held at zero in idle so every sync cycle has the same length
  always_comb begin
    cnt_d = cnt_q;
    if (!sync_busy) begin
      cnt_d = '0;
    end else if (!sync_last) begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // pulse at the end of the cycle, together with busy dropping
  always_comb begin
    sync_d = sync_busy && sync_last;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
    end
  end

  // readback returns the whole stored word
  assign cfg_rdata = cfg_q;
  // level follows the bit, so drivers stay in reset until software clears it
  assign out_pair_a_driver_reset = out_rst_bit;
  assign loop_a_phase_back = back_step_q;
  // both loops share one flop so their pulses never skew
  assign sync_pulse_loop_a = sync_q;
  assign sync_pulse_loop_b = sync_q;
  assign force_reset_busy = sync_busy;

  // feedback divider reset after changes is software's duty
  pldrc_ratio u_ratio (
    .mclk(mclk),
    .srst(srst),
    .rational_en(rational_bit),
    .interp_order(interp_order),
    .loop_a_denominator_hi(den_hi_bits),
    .loop_a_frac_divisor(loop_a_frac_divisor),
    .ratio(ratio)
  );
endmodule : pll_divider_rational_ctrl

// File: pldrc_checker.sv
// checker: port assertions for the loop control fields
`timescale 1ns/1ps
module pldrc_checker (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cfg_wr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [1:0] interp_order,
  input wire logic [27:0] loop_a_frac_divisor,
  input wire logic [31:0] cfg_rdata,
  input wire logic out_pair_a_driver_reset,
  input wire logic sync_pulse_loop_a,
  input wire logic sync_pulse_loop_b,
  input wire logic loop_a_phase_back,
  input wire logic force_reset_busy,
  input wire pldrc_pkg::pldrc_ratio_t ratio
);
  wire logic [61:0] snap = {cfg_rdata, loop_a_frac_divisor, interp_order};
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  AST_WR: assert property (cfg_wr |=> cfg_rdata == $past(cfg_wdata)) else $error("readback");
  AST_ORST: assert property (out_pair_a_driver_reset == cfg_rdata[13]) else $error("pair");
  AST_SYNC: assert property (sync_pulse_loop_a == sync_pulse_loop_b) else $error("sync");
  AST_END: assert property ($fell(force_reset_busy) |-> sync_pulse_loop_a) else $error("end");
  AST_BUSY: assert property ($rose(force_reset_busy) |-> force_reset_busy [*8] ##1
    !force_reset_busy) else $error("busy length");
  AST_PULSE: assert property (loop_a_phase_back |=> !loop_a_phase_back) else $error("pb");
  AST_EDGE: assert property (loop_a_phase_back |-> $past(cfg_rdata[11]) &&
    !$past(cfg_rdata[11], 2)) else $error("pb edge");
  AST_BACK: assert property (cfg_wr && cfg_wdata[11] && !cfg_rdata[11] |-> ##2
    loop_a_phase_back) else $error("pb late");
  AST_RAT: assert property (ratio.rational |-> ratio.denominator != 16'h0) else $error("rat");
  AST_MAP: assert property ($past(snap) == snap && $past(snap, 2) == snap |->
    ratio.numerator == loop_a_frac_divisor[24:9] && ratio.interp_bypass == (interp_order == 2'h3)
    && ratio.denominator == {cfg_rdata[9:0], loop_a_frac_divisor[5:0]}) else $error("map");
endmodule : pldrc_checker
bind pll_divider_rational_ctrl pldrc_checker chk_u (.mclk(mclk), .srst(srst), .cfg_wr(cfg_wr),
  .cfg_wdata(cfg_wdata), .interp_order(interp_order), .loop_a_frac_divisor(loop_a_frac_divisor),
  .cfg_rdata(cfg_rdata), .out_pair_a_driver_reset(out_pair_a_driver_reset),
  .sync_pulse_loop_a(sync_pulse_loop_a), .sync_pulse_loop_b(sync_pulse_loop_b),
  .loop_a_phase_back(loop_a_phase_back), .force_reset_busy(force_reset_busy), .ratio(ratio));

// File: pll_divider_rational_ctrl_tb.sv
// bench: directed scenarios for the loop control fields
`timescale 1ns/1ps
module pll_divider_rational_ctrl_tb;
  logic mclk = 0, srst = 1, cfg_wr = 0, pr, sa, sb, pb, bz;
  logic [31:0] cfg_wdata = 32'h0, rd;
  logic [1:0] io = 2'h0;
  logic [27:0] fr = 28'h0;
  pldrc_pkg::pldrc_ratio_t rt;
  int errors = 0, checks = 0, cyc = 0, n_pb, n_bz, n_sy, n_sb;
  always #2 mclk = ~mclk;
  pll_divider_rational_ctrl dut_u (.mclk(mclk), .srst(srst), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .interp_order(io), .loop_a_frac_divisor(fr), .cfg_rdata(rd),
    .out_pair_a_driver_reset(pr), .sync_pulse_loop_a(sa), .sync_pulse_loop_b(sb),
    .loop_a_phase_back(pb), .force_reset_busy(bz), .ratio(rt));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // entered and left just after a rising edge
  task automatic wr(input logic [31:0] d);
    cfg_wdata = d;
    cfg_wr = 1'h1;
    @(posedge mclk);
    #1 cfg_wr = 1'h0;
  endtask : wr
  task automatic run(input int n);
    n_pb = 0;
    n_bz = 0;
    n_sy = 0;
    n_sb = 0;
    repeat (n) begin
      @(posedge mclk);
      #1 n_pb += pb;
      n_bz += bz;
      n_sy += sa;
      n_sb += sb;
    end
  endtask : run
  task automatic sc_pair();
    wr(32'h2000);
    run(2);
    chk("pair_set", pr, 32'h1);
    run(20);
    chk("pair_hold", pr, 32'h1);
    wr(32'h0);
    run(2);
    chk("pair_clr", pr, 32'h0);
  endtask : sc_pair
  task automatic sc_phase();
    wr(32'h800);
    run(4);
    chk("pb_once", n_pb, 32'h1);
    wr(32'h800);
    run(4);
    chk("pb_held", n_pb, 32'h0);
    wr(32'h0);
    run(1);
    wr(32'h800);
    run(4);
    chk("pb_rearm", n_pb, 32'h1);
  endtask : sc_phase
  task automatic sc_sync();
    wr(32'h1000);
    run(14);
    chk("busy", n_bz, 32'h8);
    chk("sync", n_sy, 32'h1);
    chk("sync_b", n_sb, 32'h1);
    chk("rd", rd, 32'h1000);
  endtask : sc_sync
  task automatic sc_ratio();
    fr = 28'h0010025;
    for (int i = 0; i < 4; i++) begin
      io = i[1:0];
      wr(32'h403);
      run(3);
      chk("bypass", rt.interp_bypass, i == 3);
    end
    chk("den", rt.denominator, 32'h00e5);
    chk("num", rt.numerator, 32'h0080);
    chk("rat", rt.rational, 32'h1);
    chk("invalid", rt.invalid, 32'h0);
    fr = 28'h0010000;
    // divider changed: pulse bit 14 of the word, which no logic here decodes
    wr(32'h4400);
    run(1);
    wr(32'h400);
    run(3);
    chk("rat_zero", rt.rational, 32'h0);
    chk("fixed", rt.fixed_frac, fr);
    wr(32'h003);
    run(3);
    chk("rat_off", rt.rational, 32'h0);
  endtask : sc_ratio
  task automatic conclude();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  // ceiling well above the hundred or so cycles the scenarios need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge mclk);
    #1 srst = 1'h0;
    sc_pair();
    sc_phase();
    sc_sync();
    sc_ratio();
    conclude();
  end
endmodule : pll_divider_rational_ctrl_tb
